// ===== hw/sarc_reply_coder.sv
// Reply coder: acknowledgement selection and state report
// Functional notes
// (R1) Reject state-forbidden commands with that state's code
// (R2) Point-to-point allows controller 1, motors A-D only
// (R3) Absent or no-drive motor gives its code
// (R4) IO-owned flags reject serial set attempts
// (R5) Unknown motion profile gives its code
// (R6) Profile for other motor type refused
// (R7) Non-serial run mode gives its code
// (R8) Slave motor rejects forbidden commands
// (R9) Command wrong for motor type refused
// (R10) Four normal states, each own code
// (R11) System error reports its fault code
// (R12) Motor error names motor and fault
// (R13) System fault codes two through six
// (R14) Motor fault codes one through four
// (R15) Motor fault codes six, seven, eight
// (R16) Position query returns per-type increment
// (R17) Host should query increment, not assume
// (R18) Letters W, D, R for states
// (R19) Syntax errors each get distinct code
// (R20) Exactly one acknowledgement per command
// (R21) Internal and unknown errors have own codes
`default_nettype none
module sarc_reply_coder
  import sarc_pkg::*;
#(
  parameter int NUM_MOTORS = 4
)
(
  input wire logic clock,
  input wire logic srst,
  input wire logic cmd_valid,
  input wire sarc_cmd_t cmd,
  input wire sarc_state_t ctrl_state,
  input wire logic p2p_mode,
  input wire logic io_flags_owned,
  input wire sarc_motor_cfg_t [NUM_MOTORS-1:0] motor_cfg,
  input wire sarc_prof_t prof_info,
  input wire logic err_is_motor,
  input wire logic [1:0] err_motor,
  input wire logic [2:0] sys_err_sel,
  input wire logic [2:0] mot_err_sel,
  output logic reply_valid,
  output sarc_reply_t reply,
  output logic [7:0] state_char,
  output logic [3:0] fault_code,
  output logic fault_valid
);

  ////////////////////////////////////////////////////////////////////////
  // Fault code mapping

  function automatic logic [3:0] sys_code(input logic [2:0] sel);
    logic [3:0] c;
    c = 4'h0;
    unique case (sel) // R13
      3'h0: c = SYS_PWR_LOW;
      3'h1: c = SYS_PWR_HIGH;
      3'h2: c = SYS_SIG_LOW;
      3'h3: c = SYS_SIG_HIGH;
      3'h4: c = SYS_HOT;
      default: c = 4'h0;
    endcase
    return c;
  endfunction

  function automatic logic [3:0] mot_code(input logic [2:0] sel);
    logic [3:0] c;
    c = 4'h0;
    unique case (sel)
      3'h0: c = MOT_OVERLOAD; // R14
      3'h1: c = MOT_HOT; // R14
      3'h2: c = MOT_FOLLOW; // R14
      3'h3: c = MOT_SLIDER; // R14
      3'h4: c = MOT_INIT; // R15
      3'h5: c = MOT_TYPE; // R15
      3'h6: c = MOT_PROFILE; // R15
      default: c = 4'h0;
    endcase
    return c;
  endfunction

  function automatic logic [6:0] state_ack(input sarc_state_t s);
    logic [6:0] a;
    a = ACK_UNKNOWN;
    unique case (s)
      SARC_ST_WFD: a = ACK_ST_WFD;
      SARC_ST_DIS: a = ACK_ST_DIS;
      SARC_ST_INIT: a = ACK_ST_INIT;
      SARC_ST_ERR: a = ACK_ST_ERR;
      SARC_ST_RUN: a = ACK_ST_RUN;
      default: a = ACK_UNKNOWN;
    endcase
    return a;
  endfunction

  function automatic logic [2:0] state_idx(input sarc_state_t s);
    logic [2:0] i;
    i = 3'h0;
    unique case (s)
      SARC_ST_WFD: i = 3'h0;
      SARC_ST_DIS: i = 3'h1;
      SARC_ST_INIT: i = 3'h2;
      SARC_ST_ERR: i = 3'h3;
      SARC_ST_RUN: i = 3'h4;
      default: i = 3'h0;
    endcase
    return i;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Motor lookup

  sarc_motor_cfg_t mcfg;
  logic motor_in_range;
  logic [1:0] mtype_bit;
  logic [NUM_MOTORS-1:0] motor_hit;

  // One match line per motor
  for (genvar g = 0; g < NUM_MOTORS; g++)
  begin
    assign motor_hit[g] = ({27'h0, cmd.motor_sel} == 32'(g));
  end

  always_comb
  begin
    mcfg = '0;
    motor_in_range = ({27'h0, cmd.motor_sel} < 32'(NUM_MOTORS));
    for (int i = 0; i < NUM_MOTORS; i++)
    begin
      if (motor_hit[i])
      begin
        mcfg = motor_cfg[i];
      end
    end
    mtype_bit = mcfg.mtype;
  end

  ////////////////////////////////////////////////////////////////////////
  // Individual checks

  logic bad_sel;
  logic no_motor;
  logic state_bad;
  logic flag_bad;
  logic mode_bad;
  logic slave_bad;
  logic type_bad;
  logic prof_missing;
  logic prof_wrong;

  always_comb
  begin
    bad_sel = p2p_mode &&
      ((cmd.ctrl_id != P2P_CTRL_ID) || (cmd.has_motor && (cmd.motor_sel > P2P_MOTOR_MAX))); // R2
    no_motor = cmd.has_motor && (!motor_in_range || !mcfg.present || (mcfg.mtype == SARC_MT_NONE)); // R3
    state_bad = !cmd.allowed_states[state_idx(ctrl_state)]; // R1
    flag_bad = cmd.sets_io_flag && io_flags_owned; // R4
    mode_bad = cmd.has_motor && cmd.needs_serial && (mcfg.run_mode != SARC_RM_SERIAL); // R7
    slave_bad = cmd.has_motor && cmd.slave_forbidden && mcfg.is_slave; // R8
    type_bad = cmd.has_motor && !cmd.mtype_mask[mtype_bit]; // R9
    prof_missing = cmd.selects_profile && !prof_info.stored; // R5
    prof_wrong = cmd.starts_profile && (prof_info.built_for != mcfg.mtype); // R6
  end

  ////////////////////////////////////////////////////////////////////////
  // Position increment of the selected motor

  logic [31:0] inc_sel;

  always_comb
  begin
    inc_sel = 32'h0;
    unique case (mcfg.mtype) // R16
      SARC_MT_NONE: inc_sel = 32'h0;
      SARC_MT_LINEAR: inc_sel = INC_LINEAR_PM;
      SARC_MT_STEPPER: inc_sel = INC_STEPPER;
      SARC_MT_SOLENOID: inc_sel = INC_SOLENOID_UA;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Check chain, first failure wins

  logic [6:0] ack_d;
  logic err_d;
  logic [31:0] inc_d;

  always_comb
  begin
    ack_d = ACK_OK;
    err_d = 1'b1;
    inc_d = 32'h0;
    if (cmd.internal_err)
      ack_d = ACK_INTERNAL; // R21
    else if (cmd.unknown_err)
      ack_d = ACK_UNKNOWN; // R21
    else if (cmd.fmt_err)
      ack_d = ACK_FORMAT; // R19
    else if (cmd.long_err)
      ack_d = ACK_TOO_LONG; // R19
    else if (cmd.sign_err)
      ack_d = ACK_SIGN; // R19
    else if (cmd.range_err)
      ack_d = ACK_RANGE; // R19
    else if (bad_sel)
      ack_d = ACK_BAD_SEL; // R2
    else if (no_motor)
      ack_d = ACK_NO_MOTOR; // R3
    else if (state_bad)
      ack_d = state_ack(ctrl_state); // R1
    else if (flag_bad)
      ack_d = ACK_FLAG_IO; // R4
    else if (mode_bad)
      ack_d = ACK_NOT_SERIAL; // R7
    else if (slave_bad)
      ack_d = ACK_SLAVE; // R8
    else if (type_bad)
      ack_d = ACK_MTYPE; // R9
    else if (prof_missing)
      ack_d = ACK_NO_PROFILE; // R5
    else if (prof_wrong)
      ack_d = ACK_PROF_TYPE; // R6
    else
    begin
      err_d = 1'b0; // R20
      if (cmd.is_pos_query)
        inc_d = inc_sel; // R16
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Reply registers, one reply per command

  logic [6:0] ack_q;
  logic err_q;
  logic [31:0] inc_q;

  always_ff @(posedge clock)
  begin
    if (srst)
      reply_valid <= 1'b0;
    else
      reply_valid <= cmd_valid; // R20
  end

  always_ff @(posedge clock)
  begin
    if (srst)
      ack_q <= ACK_RESET;
    else if (cmd_valid)
      ack_q <= ack_d;
  end

  always_ff @(posedge clock)
  begin
    if (srst)
      err_q <= 1'b0;
    else if (cmd_valid)
      err_q <= err_d; // R20
  end

  always_ff @(posedge clock)
  begin
    if (srst)
      inc_q <= 32'h0;
    else if (cmd_valid)
      inc_q <= inc_d; // R16
  end

  assign reply = '{
    ack: ack_q,
    is_error: err_q,
    increment: inc_q
  };

  ////////////////////////////////////////////////////////////////////////
  // Fault codes for the report

  logic [3:0] sys_fault_code;
  logic [3:0] mot_fault_code;

  assign sys_fault_code = sys_code(sys_err_sel); // R13
  assign mot_fault_code = mot_code(mot_err_sel); // R14

  ////////////////////////////////////////////////////////////////////////
  // State report

  sarc_state_report u_report (
    .clock(clock),
    .srst(srst),
    .ctrl_state(ctrl_state),
    .err_is_motor(err_is_motor),
    .err_motor(err_motor),
    .sys_fault(sys_fault_code),
    .mot_fault(mot_fault_code),
    .state_char(state_char),
    .fault_code(fault_code),
    .fault_valid(fault_valid)
  );

endmodule
`default_nettype wire

// ===== hw/sarc_pkg.sv
// Package for the servo reply coder: codes, kinds and carriers
`default_nettype none
package sarc_pkg;
  // Acknowledgement codes, numeric part after the E prefix
  localparam logic [6:0] ACK_OK = 7'h43;
  localparam logic [6:0] ACK_ST_WFD = 7'h32;
  localparam logic [6:0] ACK_ST_DIS = 7'h33;
  localparam logic [6:0] ACK_ST_INIT = 7'h34;
  localparam logic [6:0] ACK_ST_ERR = 7'h35;
  localparam logic [6:0] ACK_ST_RUN = 7'h36;
  localparam logic [6:0] ACK_INTERNAL = 7'h37;
  localparam logic [6:0] ACK_BAD_SEL = 7'h38;
  localparam logic [6:0] ACK_NO_MOTOR = 7'h39;
  localparam logic [6:0] ACK_UNKNOWN = 7'h3A;
  localparam logic [6:0] ACK_FORMAT = 7'h3B;
  localparam logic [6:0] ACK_SIGN = 7'h3C;
  localparam logic [6:0] ACK_FLAG_IO = 7'h3D;
  localparam logic [6:0] ACK_NO_PROFILE = 7'h3E;
  localparam logic [6:0] ACK_PROF_TYPE = 7'h3F;
  localparam logic [6:0] ACK_RANGE = 7'h40;
  localparam logic [6:0] ACK_TOO_LONG = 7'h41;
  localparam logic [6:0] ACK_NOT_SERIAL = 7'h42;
  // Okay and E67 share 67; is_error tells them apart
  localparam logic [6:0] ACK_SLAVE = 7'h43;
  localparam logic [6:0] ACK_MTYPE = 7'h44;

  // State letters of the state report
  localparam logic [7:0] ST_CHR_WFD = 8'h57;
  localparam logic [7:0] ST_CHR_DIS = 8'h44;
  localparam logic [7:0] ST_CHR_RUN = 8'h52;
  localparam logic [7:0] ST_CHR_INIT = 8'h49;
  localparam logic [7:0] ST_CHR_SYS = 8'h45;
  localparam logic [7:0] ST_CHR_MOT_A = 8'h41;

  // System fault codes
  localparam logic [3:0] SYS_PWR_LOW = 4'h2;
  localparam logic [3:0] SYS_PWR_HIGH = 4'h3;
  localparam logic [3:0] SYS_SIG_LOW = 4'h4;
  localparam logic [3:0] SYS_SIG_HIGH = 4'h5;
  localparam logic [3:0] SYS_HOT = 4'h6;

  // Motor fault codes
  localparam logic [3:0] MOT_OVERLOAD = 4'h1;
  localparam logic [3:0] MOT_HOT = 4'h2;
  localparam logic [3:0] MOT_FOLLOW = 4'h3;
  localparam logic [3:0] MOT_SLIDER = 4'h4;
  localparam logic [3:0] MOT_INIT = 4'h6;
  localparam logic [3:0] MOT_TYPE = 4'h7;
  localparam logic [3:0] MOT_PROFILE = 4'h8;

  // Position increments, in pm, eighth steps and uA
  localparam logic [31:0] INC_LINEAR_PM = 32'h012A05F2;
  localparam logic [31:0] INC_STEPPER = 32'h00000001;
  localparam logic [31:0] INC_SOLENOID_UA = 32'h00005B8E;

  // Controller and motor address limits in point-to-point mode
  localparam logic [2:0] P2P_CTRL_ID = 3'h1;
  localparam logic [4:0] P2P_MOTOR_MAX = 5'h03;

  // Reset value of the acknowledgement output
  localparam logic [6:0] ACK_RESET = 7'h00;

  typedef enum logic [2:0] {
    SARC_ST_WFD = 3'b000,
    SARC_ST_DIS = 3'b001,
    SARC_ST_INIT = 3'b011,
    SARC_ST_RUN = 3'b010,
    SARC_ST_ERR = 3'b110
  } sarc_state_t;

  typedef enum logic [1:0] {
    SARC_MT_NONE = 2'b00,
    SARC_MT_LINEAR = 2'b01,
    SARC_MT_STEPPER = 2'b10,
    SARC_MT_SOLENOID = 2'b11
  } sarc_mtype_t;

  typedef enum logic [1:0] {
    SARC_RM_SERIAL = 2'b00,
    SARC_RM_OTHER = 2'b01,
    SARC_RM_IO = 2'b10,
    SARC_RM_ANALOG = 2'b11
  } sarc_runmode_t;

  // Decoded command as it leaves the parser
  typedef struct packed {
    logic [4:0] allowed_states;
    logic has_motor;
    logic [2:0] ctrl_id;
    logic [4:0] motor_sel;
    logic sets_io_flag;
    logic selects_profile;
    logic [7:0] profile_num;
    logic starts_profile;
    logic needs_serial;
    logic slave_forbidden;
    logic [3:0] mtype_mask;
    logic is_pos_query;
    logic fmt_err;
    logic sign_err;
    logic range_err;
    logic long_err;
    logic internal_err;
    logic unknown_err;
  } sarc_cmd_t;

  // Per-motor configuration
  typedef struct packed {
    logic present;
    sarc_mtype_t mtype;
    sarc_runmode_t run_mode;
    logic is_slave;
  } sarc_motor_cfg_t;

  // Per-motor profile table entry lookup result
  typedef struct packed {
    logic stored;
    sarc_mtype_t built_for;
  } sarc_prof_t;

  // Reply leaving the coder
  typedef struct packed {
    logic [6:0] ack;
    logic is_error;
    logic [31:0] increment;
  } sarc_reply_t;
endpackage
`default_nettype wire

// ===== hw/sarc_state_report.sv
// State report encoder of the servo reply coder
`default_nettype none
module sarc_state_report
  import sarc_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire sarc_state_t ctrl_state,
  input wire logic err_is_motor,
  input wire logic [1:0] err_motor,
  input wire logic [3:0] sys_fault,
  input wire logic [3:0] mot_fault,
  output logic [7:0] state_char,
  output logic [3:0] fault_code,
  output logic fault_valid
);

  logic [7:0] char_d;
  logic [3:0] code_d;
  logic valid_d;

  always_comb
  begin
    char_d = ST_CHR_WFD;
    code_d = 4'h0;
    valid_d = 1'b0;
    unique case (ctrl_state)
      SARC_ST_WFD: char_d = ST_CHR_WFD; // R18
      SARC_ST_DIS: char_d = ST_CHR_DIS; // R18
      SARC_ST_RUN: char_d = ST_CHR_RUN; // R18
      SARC_ST_INIT: char_d = ST_CHR_INIT; // R10
      SARC_ST_ERR:
      begin
        valid_d = 1'b1;
        if (err_is_motor)
        begin
          char_d = ST_CHR_MOT_A + {6'h00, err_motor}; // R12
          code_d = mot_fault; // R12
        end
        else
        begin
          char_d = ST_CHR_SYS;
          code_d = sys_fault; // R11
        end
      end
      default: char_d = ST_CHR_WFD;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      state_char <= ST_CHR_WFD;
      fault_code <= 4'h0;
      fault_valid <= 1'b0;
    end
    else
    begin
      state_char <= char_d;
      fault_code <= code_d;
      fault_valid <= valid_d;
    end
  end

endmodule
`default_nettype wire

// ===== dv/sarc_host_model.sv
// Host-side command source for the servo reply coder
`default_nettype none
module sarc_host_model
  import sarc_pkg::*;
(
  input wire logic clock,
  output var logic cmd_valid,
  output var sarc_cmd_t cmd
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    cmd_valid = 1'b0;
    cmd = '0;
  end
  // One command, optional idle gap, garbage after release
  task automatic send(input sarc_cmd_t c, input int gap);
    repeat (gap) @(posedge clock);
    @(posedge clock);
    #1;
    cmd = c;
    cmd_valid = 1'b1;
    @(posedge clock);
    #1;
    cmd_valid = 1'b0;
    cmd = ~c;
  endtask
endmodule
`default_nettype wire

// ===== dv/sarc_reply_coder_asserts.sv
// Assertion checker for the servo reply coder
`default_nettype none
module sarc_reply_coder_asserts
  import sarc_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire logic cmd_valid,
  input wire sarc_cmd_t cmd,
  input wire sarc_state_t ctrl_state,
  input wire logic err_is_motor,
  input wire logic [1:0] err_motor,
  input wire logic [2:0] sys_err_sel,
  input wire logic [2:0] mot_err_sel,
  input wire logic reply_valid,
  input wire sarc_reply_t reply,
  input wire logic [7:0] state_char,
  input wire logic [3:0] fault_code,
  input wire logic fault_valid
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  property p_reply; cmd_valid |=> reply_valid; endproperty
  a_reply: assert property (p_reply) else $error("command without reply");
  property p_no_extra; !cmd_valid |=> !reply_valid && $stable(reply); endproperty
  a_no_extra: assert property (p_no_extra) else $error("reply without command");
  property p_internal; cmd_valid && cmd.internal_err |=> reply.ack == ACK_INTERNAL && reply.is_error; endproperty
  a_internal: assert property (p_internal) else $error("internal error code wrong");
  property p_run_rej;
    cmd_valid && cmd[5:0] == 6'h00 && !cmd.has_motor && cmd.ctrl_id == P2P_CTRL_ID && ctrl_state == SARC_ST_RUN
      && !cmd.allowed_states[4] |=> reply.ack == ACK_ST_RUN && reply.is_error;
  endproperty
  a_run_rej: assert property (p_run_rej) else $error("run state rejection wrong");
  property p_run_chr; ctrl_state == SARC_ST_RUN |=> state_char == ST_CHR_RUN && !fault_valid; endproperty
  a_run_chr: assert property (p_run_chr) else $error("run letter wrong");
  property p_wfd; ctrl_state == SARC_ST_WFD |=> state_char == ST_CHR_WFD && fault_code == 4'h0; endproperty
  a_wfd: assert property (p_wfd) else $error("wait state report wrong");
  property p_sys;
    ctrl_state == SARC_ST_ERR && !err_is_motor && sys_err_sel == 3'h4 |=> fault_code == SYS_HOT && fault_valid;
  endproperty
  a_sys: assert property (p_sys) else $error("system fault code wrong");
  property p_mot;
    ctrl_state == SARC_ST_ERR && err_is_motor && mot_err_sel == 3'h6
      |=> fault_code == MOT_PROFILE && state_char == ST_CHR_MOT_A + {6'h00, $past(err_motor)};
  endproperty
  a_mot: assert property (p_mot) else $error("motor fault report wrong");
endmodule
bind sarc_reply_coder sarc_reply_coder_asserts i_sarc_reply_coder_asserts (
  .clock(clock), .srst(srst), .cmd_valid(cmd_valid), .cmd(cmd), .ctrl_state(ctrl_state),
  .err_is_motor(err_is_motor), .err_motor(err_motor), .sys_err_sel(sys_err_sel), .mot_err_sel(mot_err_sel),
  .reply_valid(reply_valid), .reply(reply), .state_char(state_char), .fault_code(fault_code),
  .fault_valid(fault_valid)
);
`default_nettype wire

// ===== dv/sarc_reply_coder_test.sv
// Testbench for the servo reply coder
`default_nettype none
module sarc_reply_coder_test
  import sarc_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  logic clock, srst, cmd_valid, p2p_mode, io_flags_owned, err_is_motor, reply_valid, fault_valid;
  logic [1:0] err_motor;
  logic [2:0] sys_err_sel, mot_err_sel;
  logic [7:0] state_char;
  logic [3:0] fault_code;
  int cycles, fails, compares;
  sarc_cmd_t cmd, c;
  sarc_state_t ctrl_state;
  sarc_motor_cfg_t [3:0] motor_cfg;
  sarc_prof_t prof_info;
  sarc_reply_t reply;
  sarc_state_t ast [5] = '{SARC_ST_WFD, SARC_ST_DIS, SARC_ST_INIT, SARC_ST_ERR, SARC_ST_RUN};
  logic [7:0] nch [5] = '{ST_CHR_WFD, ST_CHR_DIS, ST_CHR_INIT, ST_CHR_SYS, ST_CHR_RUN};
  logic [5:0] sm [6] = '{6'h3F, 6'h3D, 6'h3C, 6'h1C, 6'h18, 6'h08};
  logic [6:0] sa [6] = '{ACK_INTERNAL, ACK_UNKNOWN, ACK_FORMAT, ACK_TOO_LONG, ACK_SIGN, ACK_RANGE};
  logic [3:0] mf [7] = '{MOT_OVERLOAD, MOT_HOT, MOT_FOLLOW, MOT_SLIDER, MOT_INIT, MOT_TYPE, MOT_PROFILE};
  sarc_host_model i_sarc_host_model (.clock(clock), .cmd_valid(cmd_valid), .cmd(cmd));
  sarc_reply_coder i_sarc_reply_coder (.clock(clock), .srst(srst), .cmd_valid(cmd_valid), .cmd(cmd),
    .ctrl_state(ctrl_state), .p2p_mode(p2p_mode), .io_flags_owned(io_flags_owned), .motor_cfg(motor_cfg),
    .prof_info(prof_info), .err_is_motor(err_is_motor), .err_motor(err_motor), .sys_err_sel(sys_err_sel),
    .mot_err_sel(mot_err_sel), .reply_valid(reply_valid), .reply(reply), .state_char(state_char),
    .fault_code(fault_code), .fault_valid(fault_valid));
  ////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("Compares %0d, mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic sarc_cmd_t base(input logic [4:0] m);
    sarc_cmd_t b;
    b = '0;
    b.allowed_states = 5'h1F;
    b.has_motor = 1'b1;
    b.ctrl_id = P2P_CTRL_ID;
    b.motor_sel = m;
    b.mtype_mask = 4'hF;
    return b;
  endfunction
  // Send one command and check its single reply
  task automatic chk(input sarc_cmd_t k, input logic [6:0] ack, input logic [31:0] inc, input logic is_err = 1'b0);
    i_sarc_host_model.send(k, compares % 2);
    cmp(reply_valid, 1'b1);
    cmp(reply.ack, ack);
    cmp(reply.is_error, (ack != ACK_OK) || is_err);
    if (k.is_pos_query)
      cmp(reply.increment, inc);
  endtask
  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      fails++;
      end_sim();
    end
  end
  initial
  begin
    srst = 1'b1;
    ctrl_state = SARC_ST_RUN;
    p2p_mode = 1'b1;
    io_flags_owned = 1'b0;
    err_is_motor = 1'b0;
    err_motor = 2'h0;
    sys_err_sel = 3'h0;
    mot_err_sel = 3'h0;
    motor_cfg[0] = '{1'b1, SARC_MT_LINEAR, SARC_RM_SERIAL, 1'b0};
    motor_cfg[1] = '0;
    motor_cfg[2] = '{1'b1, SARC_MT_NONE, SARC_RM_SERIAL, 1'b0};
    motor_cfg[3] = '{1'b1, SARC_MT_STEPPER, SARC_RM_IO, 1'b1};
    prof_info = '{1'b1, SARC_MT_LINEAR};
    repeat (16) @(posedge clock);
    #1;
    cmp(state_char, ST_CHR_WFD);
    cmp({reply_valid, fault_valid, fault_code, reply.ack}, 32'h0);
    srst = 1'b0;
    chk(base(5'h00), ACK_OK, 32'h0);
    for (int i = 0; i < 6; i++)
    begin
      c = base(5'h00);
      c[5:0] = sm[i];
      chk(c, sa[i], 32'h0);
    end
    c.ctrl_id = 3'h2;
    chk(c, ACK_RANGE, 32'h0);
    c = base(5'h00);
    c.ctrl_id = 3'h2;
    chk(c, ACK_BAD_SEL, 32'h0);
    c.has_motor = 1'b0;
    chk(c, ACK_BAD_SEL, 32'h0);
    chk(base(5'h04), ACK_BAD_SEL, 32'h0);
    p2p_mode = 1'b0;
    chk(base(5'h04), ACK_NO_MOTOR, 32'h0);
    p2p_mode = 1'b1;
    chk(base(5'h01), ACK_NO_MOTOR, 32'h0);
    chk(base(5'h02), ACK_NO_MOTOR, 32'h0);
    for (int i = 0; i < 5; i++)
    begin
      ctrl_state = ast[i];
      c = base(5'h00);
      c.has_motor = 1'b0;
      c.allowed_states[i] = 1'b0;
      chk(c, ACK_ST_WFD + 7'(i), 32'h0);
    end
    io_flags_owned = 1'b1;
    c = base(5'h00);
    c.sets_io_flag = 1'b1;
    chk(c, ACK_FLAG_IO, 32'h0);
    io_flags_owned = 1'b0;
    chk(c, ACK_OK, 32'h0);
    c = base(5'h03);
    c.needs_serial = 1'b1;
    chk(c, ACK_NOT_SERIAL, 32'h0);
    c = base(5'h03);
    c.slave_forbidden = 1'b1;
    chk(c, ACK_SLAVE, 32'h0, 1'b1);
    c = base(5'h03);
    c.mtype_mask = 4'hB;
    chk(c, ACK_MTYPE, 32'h0);
    c = base(5'h00);
    c.is_pos_query = 1'b1;
    chk(c, ACK_OK, INC_LINEAR_PM);
    c.motor_sel = 5'h03;
    chk(c, ACK_OK, INC_STEPPER);
    motor_cfg[2].mtype = SARC_MT_SOLENOID;
    c.motor_sel = 5'h02;
    chk(c, ACK_OK, INC_SOLENOID_UA);
    prof_info = '{1'b0, SARC_MT_LINEAR};
    c = base(5'h00);
    c.selects_profile = 1'b1;
    chk(c, ACK_NO_PROFILE, 32'h0);
    prof_info = '{1'b1, SARC_MT_STEPPER};
    c.starts_profile = 1'b1;
    chk(c, ACK_PROF_TYPE, 32'h0);
    for (int i = 0; i < 5; i++)
    begin
      ctrl_state = ast[i];
      @(posedge clock);
      #1;
      cmp(state_char, nch[i]);
    end
    ctrl_state = SARC_ST_ERR;
    for (int i = 0; i < 5; i++)
    begin
      sys_err_sel = 3'(i);
      @(posedge clock);
      #1;
      cmp({fault_valid, state_char, fault_code}, {1'b1, ST_CHR_SYS, SYS_PWR_LOW + 4'(i)});
    end
    err_is_motor = 1'b1;
    for (int i = 0; i < 7; i++)
    begin
      mot_err_sel = 3'(i);
      err_motor = 2'(i % 4);
      @(posedge clock);
      #1;
      cmp({fault_valid, state_char, fault_code}, {1'b1, ST_CHR_MOT_A + 8'(i % 4), mf[i]});
    end
    end_sim();
  end
endmodule
`default_nettype wire
